// >>> verilog/csf_regs.vh
// Purpose: Constants for the clock strap and frequency select block.
// Assumes: System clock of 200 MHz; frequencies are held in 10 kHz units.
// Notes:   Each table row packs CPU, graphics and peripheral frequencies.
`ifndef CSF_REGS_VH
`define CSF_REGS_VH

// ----------------------------------------------------------------------
// Timing base
// ----------------------------------------------------------------------
`define CSF_FREQ_W 16
`define CSF_SYS_CLK_10KHZ 16'h4e20
`define CSF_SYS_CLK_HALF 16'h2710

// ----------------------------------------------------------------------
// Table row fields
// ----------------------------------------------------------------------
`define CSF_ROW_CPU 47:32
`define CSF_ROW_GFX 31:16
`define CSF_ROW_PER 15:0

// ----------------------------------------------------------------------
// Frequency table, code 0 to 15, CPU/graphics/peripheral in 10 kHz
// ----------------------------------------------------------------------
`define CSF_FTBL_0 48'h1a18_1a18_0d0c
`define CSF_FTBL_1 48'h2724_1a18_0d0c
`define CSF_FTBL_2 48'h2ee0_1770_0bb8
`define CSF_FTBL_3 48'h3415_1a0b_0d05
`define CSF_FTBL_4 48'h1c20_1c20_0e10
`define CSF_FTBL_5 48'h2904_1b58_0dac
`define CSF_FTBL_6 48'h3e80_1900_0c80
`define CSF_FTBL_7 48'h36b0_1b58_0dac
`define CSF_FTBL_8 48'h1e14_1e14_0f0a
`define CSF_FTBL_9 48'h2af8_1ca5_0e53
`define CSF_FTBL_A 48'h4650_1770_0bb8
`define CSF_FTBL_B 48'h3a98_1770_0bb8
`define CSF_FTBL_C 48'h2328_1770_0bb8
`define CSF_FTBL_D 48'h2710_1a0b_0d05
`define CSF_FTBL_E 48'h4e20_1a0b_0d05
`define CSF_FTBL_F 48'h3415_1a0b_0d05

// ----------------------------------------------------------------------
// Strap meanings and reset values
// ----------------------------------------------------------------------
`define CSF_FAMILY_A 1'b1
`define CSF_IOH_MULT_LOW 3'h4
`define CSF_IOH_MULT_HIGH 3'h6
`define CSF_REF_STRENGTH_RST 1'b0
`define CSF_CODE_RST 4'h0
`define CSF_STRAP_RST 1'b0

`endif

// >>> verilog/csf_nco.v
// Purpose: Square-wave generator at a frequency given in 10 kHz units.
// Assumes: Runs on the 200 MHz system clock.
// Notes:   Above 100 MHz the output aliases; the frequency ports still
//          report the exact selected value.
`timescale 1ns/100ps
`include "csf_regs.vh"

module csf_nco
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Control
  input wire i_run,
  input wire [`CSF_FREQ_W-1:0] i_freq,
  // Output
  output reg o_clk
);

  reg [`CSF_FREQ_W:0] acc_q;
  wire [`CSF_FREQ_W:0] sum = acc_q + {1'b0, i_freq};
  wire [`CSF_FREQ_W:0] modulus = {1'b0, `CSF_SYS_CLK_10KHZ};

  // Phase starts at zero whenever run rises, so every instance that is
  // released together stays in step with the others
  always @(posedge i_clk)
  begin
    if (i_rst || !i_run)
    begin
      acc_q <= {(`CSF_FREQ_W+1){1'b0}};
      o_clk <= 1'b0;
    end
    else
    begin
      acc_q <= (sum >= modulus) ? sum - modulus : sum;
      o_clk <= (acc_q >= {1'b0, `CSF_SYS_CLK_HALF});
    end
  end

endmodule // csf_nco

// >>> verilog/csf_clock_strap.v
// Purpose: Power-up strap latching and output configuration of a clock
//          generator: frequency code, CPU family, drive current, pins.
// Assumes: I_RST is the power-on event; I_SUPPLY_OK marks the supply
//          crossing its threshold; all inputs synchronous to I_SYS_CLK.
// Notes:   CPU, graphics and peripheral clocks are modelled from 200 MHz phase accumulators.
`timescale 1ns/100ps
`include "csf_regs.vh"

module csf_clock_strap
(
  // Clock and reset
  input wire I_SYS_CLK,
  input wire I_RST,
  // Power-up sequencing
  input wire I_SUPPLY_OK,
  input wire I_REF_STRENGTH_2X,
  input wire [2:0] I_FREQ_SELECT_HI,
  // Shared pin: select bit 0 / reference clock 0
  input wire I_SEL0_OR_REFCLK0_IN,
  output reg O_SEL0_OR_REFCLK0_OUT,
  output reg O_SEL0_OR_REFCLK0_OE,
  // Shared pin: power good (low) / reference clock 1
  input wire I_TERMINATION_POWER_GOOD_N_IN,
  output reg O_REFCLK_OUT_1,
  output reg O_TERMINATION_POWER_GOOD_N_OE,
  // Shared pin: family strap / graphics clock 1
  input wire I_CPU_FAMILY_STRAP_IN,
  output reg O_CPU_FAMILY_STRAP_OUT,
  output reg O_CPU_FAMILY_STRAP_OE,
  // Shared pin: multiplier strap / peripheral clock 2
  input wire I_CURRENT_MULTIPLIER_STRAP_IN,
  output reg O_CURRENT_MULTIPLIER_STRAP_OUT,
  output reg O_CURRENT_MULTIPLIER_STRAP_OE,
  // Clock sources
  input wire I_CRYSTAL_INPUT,
  input wire I_MEM_BUFFER_INPUT,
  // CPU clock pair, each a drive level and an enable
  output reg O_CPU_CLOCK_TRUE_OUT,
  output reg O_CPU_CLOCK_TRUE_OE,
  output reg O_CPU_CLOCK_COMP_OUT,
  output reg O_CPU_CLOCK_COMP_OE,
  // Dedicated clock outputs
  output reg [2:0] O_PERIPH_CLOCK,
  output reg [5:0] O_MEM_CLOCK_TRUE,
  output reg [5:0] O_MEM_CLOCK_COMP,
  // Status
  output reg [3:0] O_FREQ_SELECT_CODE,
  output reg O_CPU_FAMILY_A,
  output reg [2:0] O_CPU_IOH_MULT,
  output reg O_REF_STRENGTH_2X,
  output reg O_CLOCKS_ENABLED,
  output reg [`CSF_FREQ_W-1:0] O_CPU_FREQ_10KHZ,
  output reg [`CSF_FREQ_W-1:0] O_GFX_FREQ_10KHZ,
  output reg [`CSF_FREQ_W-1:0] O_PERIPH_FREQ_10KHZ
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] ST_POWER_UP = 3'h1;
  localparam [2:0] ST_WAIT_GOOD = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  reg [2:0] state_q;
  reg [3:0] code_sample_q;
  reg mult_sample_q;
  reg family_q;
  reg [3:0] code_q;
  reg mult_q;
  reg run_q;
  reg xtal_q;
  reg membuf_q;
  reg [47:0] row;
  wire cpu_clk;
  wire gfx_clk;
  wire per_clk;

  // --------------------------------------------------------------------
  // Strap sequencer
  // --------------------------------------------------------------------
  // Straps are only looked at in the first state, so later pin
  // activity cannot disturb them until I_RST returns.
  always @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      state_q <= ST_POWER_UP;
      code_sample_q <= `CSF_CODE_RST;
      mult_sample_q <= `CSF_STRAP_RST;
      family_q <= `CSF_STRAP_RST;
      code_q <= `CSF_CODE_RST;
      mult_q <= `CSF_STRAP_RST;
      run_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_POWER_UP:
        begin
          if (I_SUPPLY_OK)
          begin
            code_sample_q <= {I_FREQ_SELECT_HI, I_SEL0_OR_REFCLK0_IN};
            mult_sample_q <= I_CURRENT_MULTIPLIER_STRAP_IN;
            family_q <= I_CPU_FAMILY_STRAP_IN;
            if (I_CPU_FAMILY_STRAP_IN == `CSF_FAMILY_A)
              state_q <= ST_WAIT_GOOD;
            else
            begin
              // Family B has no power-good gate
              code_q <= {I_FREQ_SELECT_HI, I_SEL0_OR_REFCLK0_IN};
              mult_q <= I_CURRENT_MULTIPLIER_STRAP_IN;
              run_q <= 1'b1;
              state_q <= ST_RUN;
            end
          end
        end
        ST_WAIT_GOOD:
        begin
          if (!I_TERMINATION_POWER_GOOD_N_IN)
          begin
            code_q <= code_sample_q;
            mult_q <= mult_sample_q;
            run_q <= 1'b1;
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
          state_q <= ST_RUN;
        default:
          state_q <= ST_POWER_UP;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Frequency table
  // --------------------------------------------------------------------
  always @*
  begin
    case (code_q)
      4'h0: row = `CSF_FTBL_0;
      4'h1: row = `CSF_FTBL_1;
      4'h2: row = `CSF_FTBL_2;
      4'h3: row = `CSF_FTBL_3;
      4'h4: row = `CSF_FTBL_4;
      4'h5: row = `CSF_FTBL_5;
      4'h6: row = `CSF_FTBL_6;
      4'h7: row = `CSF_FTBL_7;
      4'h8: row = `CSF_FTBL_8;
      4'h9: row = `CSF_FTBL_9;
      4'ha: row = `CSF_FTBL_A;
      4'hb: row = `CSF_FTBL_B;
      4'hc: row = `CSF_FTBL_C;
      4'hd: row = `CSF_FTBL_D;
      4'he: row = `CSF_FTBL_E;
      default: row = `CSF_FTBL_F;
    endcase
  end

  // --------------------------------------------------------------------
  // Clock generators
  // --------------------------------------------------------------------
  // All three start from zero phase on the same edge of run_q.
  csf_nco u_cpu_nco
  (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_run(run_q),
    .i_freq(row[`CSF_ROW_CPU]),
    .o_clk(cpu_clk)
  );

  csf_nco u_gfx_nco
  (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_run(run_q),
    .i_freq(row[`CSF_ROW_GFX]),
    .o_clk(gfx_clk)
  );

  csf_nco u_per_nco
  (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_run(run_q),
    .i_freq(row[`CSF_ROW_PER]),
    .o_clk(per_clk)
  );

  // --------------------------------------------------------------------
  // Pin outputs
  // --------------------------------------------------------------------
  always @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      xtal_q <= 1'b0;
      membuf_q <= 1'b0;
      O_SEL0_OR_REFCLK0_OUT <= 1'b0;
      O_SEL0_OR_REFCLK0_OE <= 1'b0;
      O_REFCLK_OUT_1 <= 1'b0;
      O_TERMINATION_POWER_GOOD_N_OE <= 1'b0;
      O_CPU_FAMILY_STRAP_OUT <= 1'b0;
      O_CPU_FAMILY_STRAP_OE <= 1'b0;
      O_CURRENT_MULTIPLIER_STRAP_OUT <= 1'b0;
      O_CURRENT_MULTIPLIER_STRAP_OE <= 1'b0;
      O_CPU_CLOCK_TRUE_OUT <= 1'b0;
      O_CPU_CLOCK_TRUE_OE <= 1'b0;
      O_CPU_CLOCK_COMP_OUT <= 1'b0;
      O_CPU_CLOCK_COMP_OE <= 1'b0;
      O_PERIPH_CLOCK <= 3'h0;
      O_MEM_CLOCK_TRUE <= 6'h00;
      O_MEM_CLOCK_COMP <= 6'h00;
      O_REF_STRENGTH_2X <= `CSF_REF_STRENGTH_RST;
    end
    else
    begin
      xtal_q <= I_CRYSTAL_INPUT;
      membuf_q <= I_MEM_BUFFER_INPUT;
      O_REF_STRENGTH_2X <= I_REF_STRENGTH_2X;
      // Select, family and multiplier pins turn to outputs once the supply threshold passes,
      // the power-good pin only for family B once running; clocks on them stay low until the outputs are enabled.
      O_SEL0_OR_REFCLK0_OE <= !state_q[0];
      O_SEL0_OR_REFCLK0_OUT <= run_q & xtal_q;
      O_CPU_FAMILY_STRAP_OE <= !state_q[0];
      O_CPU_FAMILY_STRAP_OUT <= gfx_clk;
      O_CURRENT_MULTIPLIER_STRAP_OE <= !state_q[0];
      O_CURRENT_MULTIPLIER_STRAP_OUT <= per_clk;
      O_TERMINATION_POWER_GOOD_N_OE <= run_q & !family_q;
      O_REFCLK_OUT_1 <= run_q & !family_q & xtal_q;
      O_PERIPH_CLOCK <= {3{per_clk}};
      O_MEM_CLOCK_TRUE <= {6{run_q & membuf_q}};
      O_MEM_CLOCK_COMP <= {6{run_q & !membuf_q}};
      if (family_q == `CSF_FAMILY_A)
      begin
        // Push-pull pair, always driven once running
        O_CPU_CLOCK_TRUE_OUT <= cpu_clk;
        O_CPU_CLOCK_TRUE_OE <= run_q;
        O_CPU_CLOCK_COMP_OUT <= run_q & !cpu_clk;
        O_CPU_CLOCK_COMP_OE <= run_q;
      end
      else
      begin
        // Open drain: only ever pull low, the load pulls high
        O_CPU_CLOCK_TRUE_OUT <= 1'b0;
        O_CPU_CLOCK_TRUE_OE <= run_q & !cpu_clk;
        O_CPU_CLOCK_COMP_OUT <= 1'b0;
        O_CPU_CLOCK_COMP_OE <= run_q & cpu_clk;
      end
    end
  end

  // --------------------------------------------------------------------
  // Status
  // --------------------------------------------------------------------
  always @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_FREQ_SELECT_CODE <= `CSF_CODE_RST;
      O_CPU_FAMILY_A <= `CSF_STRAP_RST;
      O_CPU_IOH_MULT <= `CSF_IOH_MULT_LOW;
      O_CLOCKS_ENABLED <= 1'b0;
      O_CPU_FREQ_10KHZ <= {`CSF_FREQ_W{1'b0}};
      O_GFX_FREQ_10KHZ <= {`CSF_FREQ_W{1'b0}};
      O_PERIPH_FREQ_10KHZ <= {`CSF_FREQ_W{1'b0}};
    end
    else
    begin
      O_FREQ_SELECT_CODE <= code_q;
      O_CPU_FAMILY_A <= family_q;
      O_CPU_IOH_MULT <= mult_q ? `CSF_IOH_MULT_HIGH
                               : `CSF_IOH_MULT_LOW;
      O_CLOCKS_ENABLED <= run_q;
      O_CPU_FREQ_10KHZ <= row[`CSF_ROW_CPU];
      O_GFX_FREQ_10KHZ <= row[`CSF_ROW_GFX];
      O_PERIPH_FREQ_10KHZ <= row[`CSF_ROW_PER];
    end
  end

endmodule // csf_clock_strap

// >>> verif/csf_strap_checker_assertions.sv
// Purpose: Port checker for the clock strap block.
// Assumes: Bound to csf_clock_strap; one clock domain.
// Notes:   Clock pins are judged from the second enabled edge on.
`timescale 1ns/100ps
module csf_strap_checker
(
  // Clock and reset
  input wire I_SYS_CLK,
  input wire I_RST,
  // Inputs watched
  input wire I_TERMINATION_POWER_GOOD_N_IN,
  input wire I_CRYSTAL_INPUT,
  input wire I_MEM_BUFFER_INPUT,
  input wire I_REF_STRENGTH_2X,
  // Outputs watched
  input wire O_SEL0_OR_REFCLK0_OUT,
  input wire O_SEL0_OR_REFCLK0_OE,
  input wire O_CPU_FAMILY_STRAP_OE,
  input wire O_CURRENT_MULTIPLIER_STRAP_OE,
  input wire O_TERMINATION_POWER_GOOD_N_OE,
  input wire O_CPU_CLOCK_TRUE_OUT,
  input wire O_CPU_CLOCK_TRUE_OE,
  input wire O_CPU_CLOCK_COMP_OUT,
  input wire O_CPU_CLOCK_COMP_OE,
  input wire [5:0] O_MEM_CLOCK_TRUE,
  input wire [5:0] O_MEM_CLOCK_COMP,
  input wire [3:0] O_FREQ_SELECT_CODE,
  input wire O_CPU_FAMILY_A,
  input wire [2:0] O_CPU_IOH_MULT,
  input wire O_REF_STRENGTH_2X,
  input wire O_CLOCKS_ENABLED
);
  // ----------
  // Checks
  // ----------
  reg en_q;
  always @(posedge I_SYS_CLK)
    en_q <= I_RST ? 1'b0 : O_CLOCKS_ENABLED;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  mem_true_a: assert property (
    en_q |-> O_MEM_CLOCK_TRUE == {6{$past(I_MEM_BUFFER_INPUT, 2)}})
    else $error("memory true clocks off buffer");
  mem_comp_a: assert property (
    en_q |-> O_MEM_CLOCK_COMP == ~O_MEM_CLOCK_TRUE)
    else $error("memory complement clocks not inverted");
  ref_copy_a: assert property (
    en_q |-> O_SEL0_OR_REFCLK0_OE &&
    O_SEL0_OR_REFCLK0_OUT == $past(I_CRYSTAL_INPUT, 2))
    else $error("reference copy wrong");
  ref_drive_a: assert property (
    !$past(I_RST) && !$past(I_RST, 2) |->
    O_REF_STRENGTH_2X == $past(I_REF_STRENGTH_2X))
    else $error("reference strength not followed");
  pgood_pin_a: assert property (
    en_q |-> O_TERMINATION_POWER_GOOD_N_OE == !O_CPU_FAMILY_A)
    else $error("power good pin role wrong");
  cpu_diff_a: assert property (
    en_q && O_CPU_FAMILY_A |-> O_CPU_CLOCK_TRUE_OE &&
    O_CPU_CLOCK_COMP_OE && O_CPU_CLOCK_COMP_OUT != O_CPU_CLOCK_TRUE_OUT)
    else $error("differential CPU pair wrong");
  cpu_od_a: assert property (
    en_q && !O_CPU_FAMILY_A |-> !O_CPU_CLOCK_TRUE_OUT &&
    !O_CPU_CLOCK_COMP_OUT && O_CPU_CLOCK_TRUE_OE != O_CPU_CLOCK_COMP_OE)
    else $error("open-drain CPU pair wrong");
  strap_hold_a: assert property (
    en_q |-> $stable(O_FREQ_SELECT_CODE) && $stable(O_CPU_FAMILY_A) &&
    $stable(O_CPU_IOH_MULT) && O_CLOCKS_ENABLED)
    else $error("latched straps moved");
  strap_pins_a: assert property (
    $rose(O_CLOCKS_ENABLED) |-> O_CPU_FAMILY_STRAP_OE &&
    O_CURRENT_MULTIPLIER_STRAP_OE)
    else $error("strap pins not turned to outputs");
  pg_commit_a: assert property (
    O_CPU_FAMILY_A && $rose(O_CLOCKS_ENABLED) |->
    !$past(I_TERMINATION_POWER_GOOD_N_IN, 2))
    else $error("enabled without power good low");
  cover property ($rose(O_CLOCKS_ENABLED) && O_CPU_FAMILY_A);
  cover property ($rose(O_CLOCKS_ENABLED) && !O_CPU_FAMILY_A);
  cover property (en_q && O_CPU_IOH_MULT == 3'h6);
endmodule // csf_strap_checker

bind csf_clock_strap csf_strap_checker csf_strap_checker_i (.I_SYS_CLK,
  .I_RST, .I_TERMINATION_POWER_GOOD_N_IN, .I_CRYSTAL_INPUT,
  .I_MEM_BUFFER_INPUT, .I_REF_STRENGTH_2X, .O_SEL0_OR_REFCLK0_OUT,
  .O_SEL0_OR_REFCLK0_OE, .O_CPU_FAMILY_STRAP_OE,
  .O_CURRENT_MULTIPLIER_STRAP_OE, .O_TERMINATION_POWER_GOOD_N_OE,
  .O_CPU_CLOCK_TRUE_OUT, .O_CPU_CLOCK_TRUE_OE, .O_CPU_CLOCK_COMP_OUT,
  .O_CPU_CLOCK_COMP_OE, .O_MEM_CLOCK_TRUE, .O_MEM_CLOCK_COMP,
  .O_FREQ_SELECT_CODE, .O_CPU_FAMILY_A, .O_CPU_IOH_MULT,
  .O_REF_STRENGTH_2X, .O_CLOCKS_ENABLED);

// >>> verif/csf_far_model.sv
// Purpose: Clock sources and CPU clock loads around the strap block.
// Assumes: Crystal rate is a plain default, not a board value.
// Notes:   Buffer input is random so any lag depth becomes visible.
`timescale 1ns/100ps
module csf_far_model
#(
  parameter XTAL_HALF = 7
)
(
  // Clock
  input wire i_clk,
  // CPU pair as driven by the block
  input wire i_t_out,
  input wire i_t_oe,
  input wire i_c_out,
  input wire i_c_oe,
  // Sources and levels seen at the loads
  output reg o_xtal,
  output reg o_buf,
  output wire o_cpu_t,
  output wire o_cpu_c
);
  integer cnt = 0;
  initial o_xtal = 1'b0;
  initial o_buf = 1'b0;
  always @(posedge i_clk)
  begin
    #1;
    o_buf <= 1'($urandom);
    cnt = (cnt + 1) % XTAL_HALF;
    if (cnt == 0)
      o_xtal <= ~o_xtal;
  end
  // Terminated loads pull an undriven open-drain leg high
  assign o_cpu_t = i_t_oe ? i_t_out : 1'b1;
  assign o_cpu_c = i_c_oe ? i_c_out : 1'b1;
endmodule // csf_far_model

// >>> verif/csf_clock_strap_tb_top.sv
// Purpose: Self-checking bench for the clock strap block.
// Assumes: One power-up per reset; inputs move 1 ns after edges.
// Notes:   Clock rates judged by edge counts over 2000 cycles.
`timescale 1ns/100ps
`include "csf_regs.vh"
module csf_clock_strap_tb_top;
  // ----------
  // Bench
  // ----------
  // Rows from code f down to 0: CPU, graphics, peripheral in 10 kHz
  localparam [767:0] FTBL = {
    48'h34151a0b0d05, 48'h4e201a0b0d05, 48'h27101a0b0d05, 48'h232817700bb8,
    48'h3a9817700bb8, 48'h465017700bb8, 48'h2af81ca50e53, 48'h1e141e140f0a,
    48'h36b01b580dac, 48'h3e8019000c80, 48'h29041b580dac, 48'h1c201c200e10,
    48'h34151a0b0d05, 48'h2ee017700bb8, 48'h27241a180d0c, 48'h1a181a180d0c};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg supply = 1'b0;
  reg str2x = 1'b0;
  reg [3:0] sel = 4'h0;
  reg fam = 1'b0;
  reg mul = 1'b0;
  reg pg_n = 1'b1;
  reg en_q = 1'b0;
  wire xtal, bufin, cpu_t, cpu_c, t_out, t_oe, c_out, c_oe, en, fam_a, s2x;
  wire s0_out, s0_oe, f_out, f_oe, m_out, m_oe, refclk_out_1, pg_oe;
  wire [2:0] pclk, mult;
  wire [5:0] mt, mc;
  wire [3:0] code;
  wire [`CSF_FREQ_W-1:0] fcpu, fgfx, fper;
  integer err_count = 0;
  integer checks_done = 0;
  integer seen = 0;
  integer hung = 0;
  integer k, junk;
  logic [55:0] exp_q[$];
  // Shared pins resolve to whichever side drives them
  wire p_s0 = s0_oe ? s0_out : sel[0];
  wire p_fam = f_oe ? f_out : fam;
  wire p_mul = m_oe ? m_out : mul;
  wire p_pg = pg_oe ? refclk_out_1 : pg_n;
  always #2.5 clk = ~clk;
  csf_clock_strap csf_clock_strap_i (.I_SYS_CLK(clk), .I_RST(rst),
    .I_SUPPLY_OK(supply), .I_REF_STRENGTH_2X(str2x),
    .I_FREQ_SELECT_HI(sel[3:1]), .I_SEL0_OR_REFCLK0_IN(p_s0),
    .O_SEL0_OR_REFCLK0_OUT(s0_out), .O_SEL0_OR_REFCLK0_OE(s0_oe),
    .I_TERMINATION_POWER_GOOD_N_IN(p_pg), .O_REFCLK_OUT_1(refclk_out_1),
    .O_TERMINATION_POWER_GOOD_N_OE(pg_oe), .I_CPU_FAMILY_STRAP_IN(p_fam),
    .O_CPU_FAMILY_STRAP_OUT(f_out), .O_CPU_FAMILY_STRAP_OE(f_oe),
    .I_CURRENT_MULTIPLIER_STRAP_IN(p_mul),
    .O_CURRENT_MULTIPLIER_STRAP_OUT(m_out),
    .O_CURRENT_MULTIPLIER_STRAP_OE(m_oe), .I_CRYSTAL_INPUT(xtal),
    .I_MEM_BUFFER_INPUT(bufin), .O_CPU_CLOCK_TRUE_OUT(t_out),
    .O_CPU_CLOCK_TRUE_OE(t_oe), .O_CPU_CLOCK_COMP_OUT(c_out),
    .O_CPU_CLOCK_COMP_OE(c_oe), .O_PERIPH_CLOCK(pclk),
    .O_MEM_CLOCK_TRUE(mt), .O_MEM_CLOCK_COMP(mc),
    .O_FREQ_SELECT_CODE(code), .O_CPU_FAMILY_A(fam_a),
    .O_CPU_IOH_MULT(mult), .O_REF_STRENGTH_2X(s2x),
    .O_CLOCKS_ENABLED(en), .O_CPU_FREQ_10KHZ(fcpu),
    .O_GFX_FREQ_10KHZ(fgfx), .O_PERIPH_FREQ_10KHZ(fper));
  csf_far_model csf_far_model_i (.i_clk(clk), .i_t_out(t_out),
    .i_t_oe(t_oe), .i_c_out(c_out), .i_c_oe(c_oe), .o_xtal(xtal),
    .o_buf(bufin), .o_cpu_t(cpu_t), .o_cpu_c(cpu_c));
  task cmp_row(input logic [55:0] e, input logic [55:0] a);
    begin
      checks_done = checks_done + 1;
      if (a !== e)
      begin
        err_count = err_count + 1;
        $display("BAD %0t status %h expected %h", $time, a, e);
      end
    end
  endtask
  task cmp_bit(input logic a, input logic e);
    begin
      checks_done = checks_done + 1;
      if (a !== e)
      begin
        err_count = err_count + 1;
        $display("BAD %0t pin check %b expected %b", $time, a, e);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  // Result watcher: oldest note against the status at enable
  always @(posedge clk)
  begin
    en_q <= en;
    if (en && !en_q)
    begin
      cmp_row(exp_q.pop_front(), {code, fam_a, mult, fcpu, fgfx, fper});
      seen = seen + 1;
    end
    if (en && en_q)
    begin
      cmp_bit(cpu_t ^ cpu_c, 1'b1);
      cmp_bit(pclk == {3{m_out}}, 1'b1);
      cmp_bit(refclk_out_1, !fam_a && s0_out);
    end
  end
  task power_up(input [3:0] c, input f, input m, input integer d);
    integer i, n, pc, cc, gc;
    logic pp, cp, gp;
    begin
      rst = 1'b1;
      supply = 1'b0;
      pg_n = 1'b1;
      sel = c;
      fam = f;
      mul = m;
      str2x = 1'($urandom);
      repeat (12) tick;
      cmp_bit(s2x, 1'b0);
      rst = 1'b0;
      tick;
      supply = 1'b1;
      exp_q.push_back({c, f, m ? 3'h6 : 3'h4, FTBL[c*48 +: 48]});
      n = seen;
      tick;
      // Strap inputs moving after the threshold must not count
      sel = ~c;
      repeat (d) tick;
      cmp_bit(en, !f);
      pg_n = 1'b0;
      i = 0;
      while (seen == n && i < 40)
      begin
        tick;
        i = i + 1;
      end
      if (seen == n)
      begin
        err_count = err_count + 1;
        $display("BAD %0t clocks never enabled", $time);
        hung = 1;
      end
      pc = 0;
      cc = 0;
      gc = 0;
      pp = 1'b1;
      cp = 1'b1;
      gp = 1'b1;
      for (i = 0; i < 2000; i = i + 1)
      begin
        pg_n = 1'($urandom);
        sel = 4'($urandom);
        str2x = 1'($urandom);
        tick;
        pc = pc + (pclk[0] && !pp);
        cc = cc + (t_out && !cp);
        gc = gc + (f_out && !gp);
        pp = pclk[0];
        cp = t_out;
        gp = f_out;
      end
      n = FTBL[c*48 +: 16] / 10;
      cmp_bit(pc >= n - 1 && pc <= n + 1, 1'b1);
      n = FTBL[c*48+32 +: 16] / 10;
      if (f && n <= 1000)
        cmp_bit(cc >= n - 1 && cc <= n + 1, 1'b1);
      n = FTBL[c*48+16 +: 16] / 10;
      cmp_bit(gc >= n - 1 && gc <= n + 1, 1'b1);
    end
  endtask
  initial
  begin
    junk = $urandom(32'h6c12a657);
    for (k = 0; k < 16 && hung == 0; k = k + 1)
      power_up(k[3:0], k[0] ^ k[1], 1'($urandom), 3 + $urandom % 6);
    print_verdict;
  end
endmodule // csf_clock_strap_tb_top
